// [ibr_map.svh]
// Purpose: offsets, field positions and reset values of the hub router
// Assumes: registers reached over the model-specific register port
// Notes: register addresses, reset values and field positions live here as macros, save the p5..p1 limit fields
// Contract
// - descriptor hit forwards request to port named by 3-bit destination field
// - qualifier set: descriptor hits only when address bit 8 is zero
// - masked address bits 31:12 equal to 20-bit base declare a hit
// - 20-bit mask selects which address bits 31:12 take part in compare
// - coherent snoops go to the 3-bit coherent port, a bridge if needed
// - master limit 00 blocks, 01 one outstanding, 11 up to 15 outstanding, 10 reserved
// - limit fields: p0 15:14, p7 13:12, p5..p1 9:8 down to 1:0
// - pipelined arbitration disable limits whole hub to one outstanding
`ifndef IBR_MAP_SVH
`define IBR_MAP_SVH

// register addresses
`define IBR_MSR_DSC 32'h51010023
`define IBR_MSR_COH 32'h51010080
`define IBR_MSR_PAE 32'h51010081
`define IBR_MSR_ARB 32'h51010082

// reset values
`define IBR_DSC_DEST_RST 3'h0
`define IBR_DSC_QUAL_RST 1'b0
`define IBR_DSC_BASE_RST 20'hfffff
`define IBR_DSC_MASK_RST 20'h00000
`define IBR_COH_RST 3'h0
`define IBR_PAE_RST 16'hffff
`define IBR_ARB_DISABLE_RST 1'b0

// descriptor field positions
`define IBR_DSC_DEST_HI 63
`define IBR_DSC_DEST_LO 61
`define IBR_DSC_QUAL 60
`define IBR_DSC_BASE_HI 39
`define IBR_DSC_BASE_LO 20
`define IBR_DSC_MASK_HI 19
`define IBR_DSC_MASK_LO 0

// other field positions
`define IBR_COH_HI 2
`define IBR_PAE_HI 15
`define IBR_ARB_DISABLE_BIT 62
`define IBR_PAE_P0_LSB 14
`define IBR_PAE_P7_LSB 12
`define IBR_PAE_P6_LSB 10

// request address fields
`define IBR_ADDR_PAGE_HI 31
`define IBR_ADDR_PAGE_LO 12
`define IBR_ADDR_QUAL_BIT 8

// ports and routing
`define IBR_NUM_PORTS 8
`define IBR_UNUSED_PORT 6
`define IBR_DEFAULT_PORT 3'h4
`define IBR_OUTST_MAX 4'hf

`endif

// [ibr_pkg.sv]
// Purpose: shared types of the hub router
// Assumes: nothing beyond ibr_map.svh
// Notes: encodings are fixed by the limit field layout
package ibr_pkg;

  // master activity limit encodings
  typedef enum logic [1:0] {
    IBR_LIM_OFF = 2'h0,
    IBR_LIM_ONE = 2'h1,
    IBR_LIM_RSVD = 2'h2,
    IBR_LIM_ON = 2'h3
  } ibr_limit_t;

  typedef logic [2:0] ibr_port_t;

endpackage : ibr_pkg

// [ibr_port_limiter.sv]
// Purpose: per-port master activity gate with outstanding counter
// Assumes: done pulses only for transactions that were granted
// Notes: grant is a registered one-cycle pulse
`timescale 1ns/100ps
`include "ibr_map.svh"

module ibr_port_limiter (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // configuration
  input ibr_pkg::ibr_limit_t limit,
  input wire logic hub_ok,
  // master handshake
  input wire logic req,
  input wire logic done,
  output logic eligible,
  output logic busy,
  output logic grant_q
);

  logic [3:0] outst_q;
  logic [3:0] outst_d;
  logic grant_d;
  logic lim_one_ok;
  logic lim_on_ok;

  // reserved encoding is treated like off, the safe reading
  assign lim_one_ok = (limit == ibr_pkg::IBR_LIM_ONE) && (outst_q == 4'h0);
  assign lim_on_ok = (limit == ibr_pkg::IBR_LIM_ON) && (outst_q != `IBR_OUTST_MAX);
  assign eligible = req && (lim_one_ok || lim_on_ok);
  assign grant_d = eligible && hub_ok;
  assign busy = (outst_q != 4'h0);

  // count up on grant and down on done; both at once leave it unchanged
  always_comb begin
    outst_d = outst_q;
    if (grant_d && !done) begin
      outst_d = outst_q + 4'h1;
    end else if (!grant_d && done && busy) begin
      outst_d = outst_q - 4'h1;
    end
  end

  // counter moves with the grant so a second grant cannot slip in
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      outst_q <= 4'h0;
      grant_q <= 1'b0;
    end else begin
      outst_q <= outst_d;
      grant_q <= grant_d;
    end
  end

endmodule : ibr_port_limiter

// [ibr_hub_router.sv]
// Purpose: configuration registers, special descriptor routing, snoop
//   port select and master activity gating of the interconnect hub
// Assumes: one request per cycle on the route port; register port
//   accesses are single-cycle strobes
// Notes: route and register answers come one cycle after the strobe
`timescale 1ns/100ps
`include "ibr_map.svh"

module ibr_hub_router (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // model-specific register port
  input wire logic [31:0] msr_addr,
  input wire logic msr_wr,
  input wire logic msr_rd,
  input wire logic [63:0] msr_wdata,
  output logic [63:0] msr_rdata_q,
  output logic msr_ack_q,
  output logic msr_miss_q,
  // route request
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_snoop,
  input wire logic ext_hit,
  input wire logic [2:0] ext_port,
  // route answer
  output logic route_valid_q,
  output logic [2:0] route_port_q,
  output logic route_desc_hit_q,
  output logic route_default_q,
  output logic route_snoop_q,
  output logic route_cfg_err_q,
  // master activity
  input wire logic [7:0] mst_req,
  input wire logic [7:0] mst_done,
  output logic [7:0] mst_grant,
  output logic hub_busy_q
);

  // stored fields
  ibr_pkg::ibr_port_t dsc_dest_q;
  logic dsc_qual_q;
  logic [19:0] dsc_base_q;
  logic [19:0] dsc_mask_q;
  ibr_pkg::ibr_port_t coh_q;
  logic [15:0] pae_q;
  logic pipelined_arb_disable_q;

  // register decode
  logic sel_dsc;
  logic sel_coh;
  logic sel_pae;
  logic sel_arb;
  logic sel_any;
  logic [63:0] rd_dsc;
  logic [63:0] rd_coh;
  logic [63:0] rd_pae;
  logic [63:0] rd_arb;
  logic [63:0] rd_mux;

  assign sel_dsc = (msr_addr == `IBR_MSR_DSC);
  assign sel_coh = (msr_addr == `IBR_MSR_COH);
  assign sel_pae = (msr_addr == `IBR_MSR_PAE);
  assign sel_arb = (msr_addr == `IBR_MSR_ARB);
  assign sel_any = sel_dsc || sel_coh || sel_pae || sel_arb;

  // readback images; reserved ranges outside the stored fields read zero
  assign rd_dsc = {dsc_dest_q, dsc_qual_q, 20'h00000, dsc_base_q, dsc_mask_q};
  assign rd_coh = {61'h0, coh_q};
  assign rd_pae = {48'h0, pae_q};
  assign rd_arb = {1'b0, pipelined_arb_disable_q, 62'h0};

  // read selection, unmapped addresses answer zero
  always_comb begin
    if (sel_dsc) begin
      rd_mux = rd_dsc;
    end else if (sel_coh) begin
      rd_mux = rd_coh;
    end else if (sel_pae) begin
      rd_mux = rd_pae;
    end else if (sel_arb) begin
      rd_mux = rd_arb;
    end else begin
      rd_mux = 64'h0;
    end
  end

  // descriptor register; software keeps reserved bits, we drop them
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dsc_dest_q <= `IBR_DSC_DEST_RST;
      dsc_qual_q <= `IBR_DSC_QUAL_RST;
      dsc_base_q <= `IBR_DSC_BASE_RST;
      dsc_mask_q <= `IBR_DSC_MASK_RST;
    end else if (msr_wr && sel_dsc) begin
      dsc_dest_q <= msr_wdata[`IBR_DSC_DEST_HI:`IBR_DSC_DEST_LO];
      dsc_qual_q <= msr_wdata[`IBR_DSC_QUAL];
      dsc_base_q <= msr_wdata[`IBR_DSC_BASE_HI:`IBR_DSC_BASE_LO];
      dsc_mask_q <= msr_wdata[`IBR_DSC_MASK_HI:`IBR_DSC_MASK_LO];
    end
  end

  // coherent port select
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      coh_q <= `IBR_COH_RST;
    end else if (msr_wr && sel_coh) begin
      coh_q <= msr_wdata[`IBR_COH_HI:0];
    end
  end

  // limit fields; the port 6 pair is stored so write-as-read round trips
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pae_q <= `IBR_PAE_RST;
    end else if (msr_wr && sel_pae) begin
      pae_q <= msr_wdata[`IBR_PAE_HI:0];
    end
  end

  // arbitration control
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pipelined_arb_disable_q <= `IBR_ARB_DISABLE_RST;
    end else if (msr_wr && sel_arb) begin
      pipelined_arb_disable_q <= msr_wdata[`IBR_ARB_DISABLE_BIT];
    end
  end

  // register answer, one cycle after any strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      msr_ack_q <= 1'b0;
      msr_miss_q <= 1'b0;
      msr_rdata_q <= 64'h0;
    end else begin
      msr_ack_q <= msr_wr || msr_rd;
      msr_miss_q <= (msr_wr || msr_rd) && !sel_any;
      if (msr_rd) begin
        msr_rdata_q <= rd_mux;
      end
    end
  end

  // special descriptor hit detection
  logic [19:0] page_masked;
  logic base_match;
  logic qual_ok;
  logic desc_hit;

  assign page_masked = req_addr[`IBR_ADDR_PAGE_HI:`IBR_ADDR_PAGE_LO] & dsc_mask_q;
  assign base_match = (page_masked == dsc_base_q);
  assign qual_ok = !dsc_qual_q || !req_addr[`IBR_ADDR_QUAL_BIT];
  assign desc_hit = base_match && qual_ok;

  // route selection: snoops first, then descriptor, then the other
  // decoders, else the subtractive default port
  ibr_pkg::ibr_port_t route_port_d;
  logic cfg_err_d;
  logic default_d;

  always_comb begin
    if (req_snoop) begin
      route_port_d = coh_q;
    end else if (desc_hit) begin
      route_port_d = dsc_dest_q;
    end else if (ext_hit) begin
      route_port_d = ext_port;
    end else begin
      route_port_d = `IBR_DEFAULT_PORT;
    end
  end

  // overlapping hits are a setup fault; routing then follows the descriptor
  assign cfg_err_d = !req_snoop && desc_hit && ext_hit;
  assign default_d = !req_snoop && !desc_hit && !ext_hit;

  // route answer registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      route_valid_q <= 1'b0;
      route_port_q <= 3'h0;
      route_desc_hit_q <= 1'b0;
      route_default_q <= 1'b0;
      route_snoop_q <= 1'b0;
      route_cfg_err_q <= 1'b0;
    end else begin
      route_valid_q <= req_valid;
      if (req_valid) begin
        route_port_q <= route_port_d;
        route_desc_hit_q <= !req_snoop && desc_hit;
        route_default_q <= default_d;
        route_snoop_q <= req_snoop;
        route_cfg_err_q <= cfg_err_d;
      end
    end
  end

  // per-port master gating
  logic [7:0] port_elig;
  logic [7:0] port_busy;
  logic [7:0] first_elig;
  logic [7:0] hub_ok;
  logic any_busy;

  // with pipelining off only the lowest eligible port may start, and only
  // when nothing is in flight; this costs throughput but keeps one open
  assign first_elig = port_elig & (~port_elig + 8'h01);
  assign any_busy = |port_busy;
  assign hub_ok = pipelined_arb_disable_q ? (any_busy ? 8'h00 : first_elig) : 8'hff;

  genvar gi;
  generate
    for (gi = 0; gi < `IBR_NUM_PORTS; gi++) begin : g_port
      localparam int LSB = (gi == 0) ? `IBR_PAE_P0_LSB :
        (gi == 7) ? `IBR_PAE_P7_LSB :
        (gi == `IBR_UNUSED_PORT) ? `IBR_PAE_P6_LSB : 2 * (gi - 1);
      ibr_pkg::ibr_limit_t lim;

      // the unused port never masters whatever its reserved field holds
      assign lim = (gi == `IBR_UNUSED_PORT) ? ibr_pkg::IBR_LIM_OFF :
        ibr_pkg::ibr_limit_t'(pae_q[LSB+1:LSB]);

      ibr_port_limiter u_lim (
        .clock(clock),
        .rst_b(rst_b),
        .limit(lim),
        .hub_ok(hub_ok[gi]),
        .req(mst_req[gi]),
        .done(mst_done[gi]),
        .eligible(port_elig[gi]),
        .busy(port_busy[gi]),
        .grant_q(mst_grant[gi])
      );
    end
  endgenerate

  // hub activity status
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hub_busy_q <= 1'b0;
    end else begin
      hub_busy_q <= any_busy;
    end
  end

endmodule : ibr_hub_router

// [ibr_hub_router_props.sv]
// Purpose: port checks of the hub router
// Assumes: configuration changes only through the register port
// Notes: shadow copies of the stored fields give the expectations
`timescale 1ns/100ps
`include "ibr_map.svh"
module ibr_hub_router_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire logic [31:0] msr_addr,
  input wire logic msr_wr,
  input wire logic msr_rd,
  input wire logic [63:0] msr_wdata,
  input wire logic [63:0] msr_rdata_q,
  input wire logic msr_ack_q,
  // routing
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_snoop,
  input wire logic ext_hit,
  input wire logic route_valid_q,
  input wire logic [2:0] route_port_q,
  input wire logic route_desc_hit_q,
  input wire logic route_default_q,
  // masters
  input wire logic [7:0] mst_grant
);
  logic [63:0] dsc_q;
  logic [2:0] coh_q;
  logic [15:0] pae_q;
  logic pipe_q;
  logic hit;
  logic [2:0] dest;
  // shadow follows writes at the same edge as the device stores them
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dsc_q <= 64'h0000_00ff_fff0_0000;
      coh_q <= 3'h0;
      pae_q <= 16'hffff;
      pipe_q <= 1'b0;
    end else if (msr_wr) begin
      if (msr_addr == `IBR_MSR_DSC) dsc_q <= msr_wdata;
      if (msr_addr == `IBR_MSR_COH) coh_q <= msr_wdata[2:0];
      if (msr_addr == `IBR_MSR_PAE) pae_q <= msr_wdata[15:0];
      if (msr_addr == `IBR_MSR_ARB) pipe_q <= msr_wdata[62];
    end
  end
  // expected descriptor decision, qualifier included
  assign hit = ((req_addr[31:12] & dsc_q[19:0]) == dsc_q[39:20]) && !(dsc_q[60] && req_addr[8]);
  assign dest = dsc_q[63:61];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_route;
    req_valid && !req_snoop;
  endsequence
  sequence s_p1_off;
    !pae_q[0] ##1 !pae_q[0];
  endsequence
  a_ack_strobe: assert property ((msr_wr || msr_rd) |=> msr_ack_q)
    else $error("no register ack");
  a_coh_readback: assert property (msr_rd && msr_addr == `IBR_MSR_COH |=> msr_rdata_q == {61'h0, $past(coh_q)})
    else $error("coherent port readback wrong");
  a_snoop_route: assert property (req_valid && req_snoop |=> route_port_q == $past(coh_q))
    else $error("snoop sent to wrong port");
  a_desc_route: assert property (s_route ##0 hit |=> route_desc_hit_q && route_port_q == $past(dest))
    else $error("descriptor hit misrouted");
  a_qual_block: assert property (req_valid && dsc_q[60] && req_addr[8] |=> !route_desc_hit_q)
    else $error("qualified descriptor hit with bit 8 set");
  a_default_port: assert property (s_route ##0 (!hit && !ext_hit) |=> route_default_q && route_port_q == 3'h4)
    else $error("miss not sent to default port");
  a_valid_pulse: assert property (req_valid |=> route_valid_q)
    else $error("route answer missing");
  a_off_grant: assert property (s_p1_off |-> !mst_grant[1])
    else $error("grant on disabled port");
  a_one_outst: assert property (pae_q[15:14] == 2'h1 && mst_grant[0] |=> !mst_grant[0])
    else $error("second outstanding grant in single mode");
  a_port6_idle: assert property (mst_grant[6] == 1'b0)
    else $error("grant on unused port");
  a_pipe_single: assert property (pipe_q && $past(pipe_q) |-> $onehot0(mst_grant))
    else $error("several grants with pipelining off");
endmodule : ibr_hub_router_props

bind ibr_hub_router ibr_hub_router_props i_props (
  .clock, .rst_b, .msr_addr, .msr_wr, .msr_rd, .msr_wdata, .msr_rdata_q, .msr_ack_q,
  .req_valid, .req_addr, .req_snoop, .ext_hit, .route_valid_q, .route_port_q,
  .route_desc_hit_q, .route_default_q, .mst_grant
);

// [ibr_master_model.sv]
// Purpose: behavioural master blocks on the hub ports
// Assumes: one go pulse per request
// Notes: a request stays up until its grant is seen, so mode 11 may regrant
`timescale 1ns/100ps
module ibr_master_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // bench control
  input wire logic [7:0] go,
  input wire logic [7:0] allow,
  // hub side
  input wire logic [7:0] mst_grant,
  output logic [7:0] mst_req,
  output logic [7:0] mst_done
);
  int open_n [8];
  // dones only while allowed, each paired with an earlier grant
  always @(posedge clock or negedge rst_b) begin
    for (int i = 0; i < 8; i++) begin
      if (!rst_b) begin
        mst_req[i] <= 1'b0;
        mst_done[i] <= 1'b0;
        open_n[i] <= 0;
      end else begin
        mst_req[i] <= go[i] || (mst_req[i] && !mst_grant[i]);
        mst_done[i] <= allow[i] && open_n[i] > 0;
        open_n[i] <= open_n[i] + mst_grant[i] - (allow[i] && open_n[i] > 0);
      end
    end
  end
endmodule : ibr_master_model

// [ibr_hub_router_bench.sv]
// Purpose: register, routing and master gating tests of the hub router
// Assumes: fixed one-cycle answers on both ports
// Notes: grant counts are kept per port by the bench
`timescale 1ns/100ps
`include "ibr_map.svh"
`define CHK(n, e, s) begin \
  total_checks++; \
  if ((s) !== (e)) begin \
    n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); \
  end \
end
module ibr_hub_router_bench;
  logic clock = 0, rst_b = 0, msr_wr = 0, msr_rd = 0, req_valid = 0, req_snoop = 0;
  logic ext_hit = 0, msr_ack_q, msr_miss_q, route_valid_q, route_desc_hit_q;
  logic route_default_q, route_snoop_q, route_cfg_err_q, hub_busy_q;
  logic [31:0] msr_addr = 0, req_addr = 0;
  logic [63:0] msr_wdata = 0, msr_rdata_q;
  logic [2:0] ext_port = 0, route_port_q;
  logic [7:0] go = 0, allow = 0, mst_req, mst_done, mst_grant;
  int n_errors = 0, total_checks = 0;
  int gcnt [8] = '{default: 0};
  int lim_exp [8] = '{1, 0, 0, 2, 2, 2, 0, 0};
  always #50 clock = ~clock;
  ibr_hub_router i_dut (
    .clock, .rst_b, .msr_addr, .msr_wr, .msr_rd, .msr_wdata, .msr_rdata_q,
    .msr_ack_q, .msr_miss_q, .req_valid, .req_addr, .req_snoop, .ext_hit,
    .ext_port, .route_valid_q, .route_port_q, .route_desc_hit_q,
    .route_default_q, .route_snoop_q, .route_cfg_err_q, .mst_req, .mst_done,
    .mst_grant, .hub_busy_q
  );
  ibr_master_model i_masters (.clock, .rst_b, .go, .allow, .mst_grant, .mst_req, .mst_done);
  // grants counted per port
  always @(posedge clock) begin
    for (int i = 0; i < 8; i++) if (mst_grant[i] === 1'b1) gcnt[i]++;
  end
  task automatic wr(input logic [31:0] a, input logic [63:0] d);
    @(negedge clock);
    msr_addr = a;
    msr_wdata = d;
    msr_wr = 1'b1;
    @(negedge clock);
    msr_wr = 1'b0;
    `CHK("wr ack", 1'b1, msr_ack_q)
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [63:0] e, input logic m);
    @(negedge clock);
    msr_addr = a;
    msr_rd = 1'b1;
    @(negedge clock);
    msr_rd = 1'b0;
    `CHK("rdata", e, msr_rdata_q)
    `CHK("miss", m, msr_miss_q)
  endtask : rd
  // flags are desc hit, default, snoop, config error
  task automatic rt(input logic [31:0] a, input logic s, x, input logic [2:0] ep, p,
                    input logic [3:0] f);
    @(negedge clock);
    req_addr = a;
    req_snoop = s;
    ext_hit = x;
    ext_port = ep;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    `CHK("valid", 1'b1, route_valid_q)
    `CHK("port", p, route_port_q)
    `CHK("flags", f, {route_desc_hit_q, route_default_q, route_snoop_q, route_cfg_err_q})
  endtask : rt
  task automatic burst(input logic [7:0] ports);
    gcnt = '{default: 0};
    go = ports;
    @(negedge clock);
    go = 8'h00;
    repeat (6) @(negedge clock);
  endtask : burst
  task test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // hang guard
  initial begin
    repeat (5000) @(negedge clock);
    n_errors++;
    test_done;
  end
  initial begin
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    rd(`IBR_MSR_COH, 64'h0, 1'b0);
    rd(`IBR_MSR_PAE, 64'hffff, 1'b0);
    rd(`IBR_MSR_ARB, 64'h0, 1'b0);
    rd(`IBR_MSR_DSC, 64'h0000_00ff_fff0_0000, 1'b0);
    rd(32'h5101_0083, 64'h0, 1'b1);
    // every port code, on the snoop path and as descriptor destination
    for (int p = 0; p < 8; p++) begin
      wr(`IBR_MSR_COH, 64'(p));
      rt(32'h0, 1'b1, 1'b0, 3'h0, 3'(p), 4'h2);
      wr(`IBR_MSR_DSC, {3'(p), 21'h0, 20'h12345, 20'hfffff});
      rt(32'h1234_5000, 1'b0, 1'b0, 3'h0, 3'(p), 4'h8);
    end
    wr(`IBR_MSR_DSC, {3'h5, 21'h0, 20'h12300, 20'hfff00});
    rt(32'h123a_b000, 1'b0, 1'b0, 3'h0, 3'h5, 4'h8);
    rt(32'h124a_b000, 1'b0, 1'b0, 3'h0, 3'h4, 4'h4);
    rt(32'h124a_b000, 1'b0, 1'b1, 3'h2, 3'h2, 4'h0);
    rt(32'h123a_b000, 1'b0, 1'b1, 3'h2, 3'h5, 4'h9);
    wr(`IBR_MSR_DSC, {3'h5, 1'b1, 20'h0, 20'h12300, 20'hfff00});
    rt(32'h123a_b100, 1'b0, 1'b0, 3'h0, 3'h4, 4'h4);
    rt(32'h123a_b000, 1'b0, 1'b0, 3'h0, 3'h5, 4'h8);
    rd(`IBR_MSR_DSC, {3'h5, 1'b1, 20'h0, 20'h12300, 20'hfff00}, 1'b0);
    // p0 single, p1 and p7 off, p2 reserved code, p6 stored only, rest up to 15 outstanding
    wr(`IBR_MSR_PAE, 64'h4ff8);
    rd(`IBR_MSR_PAE, 64'h4ff8, 1'b0);
    burst(8'hff);
    foreach (gcnt[i]) `CHK("grants", lim_exp[i], gcnt[i])
    `CHK("busy", 1'b1, hub_busy_q)
    allow = 8'hff;
    wr(`IBR_MSR_PAE, 64'hffff);
    repeat (10) @(negedge clock);
    `CHK("idle", 1'b0, hub_busy_q)
    // pipelining off: one grant hub-wide, lowest port first
    allow = 8'h00;
    wr(`IBR_MSR_ARB, 64'h4000_0000_0000_0000);
    rd(`IBR_MSR_ARB, 64'h4000_0000_0000_0000, 1'b0);
    burst(8'hbf);
    foreach (gcnt[i]) `CHK("pipe grants", int'(i == 0), gcnt[i])
    test_done;
  end
endmodule : ibr_hub_router_bench
